// ### src/serdes_word_pkg.sv
// Constants, register map and types for the gigabit serdes word path
package serdes_word_pkg;

    localparam int WORD_W = 10;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int SYNC_W = 13;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] REG_CTRL = 12'h000;
    localparam logic [ADDR_W-1:0] REG_STATUS = 12'h004;
    localparam logic [ADDR_W-1:0] REG_RX_WORD = 12'h008;
    localparam logic [ADDR_W-1:0] REG_TX_HOLD = 12'h00C;

    // Field positions
    localparam int CTRL_LOOPBACK_BIT = 0;
    localparam int CTRL_ALIGN_BIT = 1;
    localparam int ST_SIGNAL_BIT = 0;
    localparam int ST_COMMA_BIT = 1;
    localparam int ST_TX_READY_BIT = 2;
    localparam int ST_BYTE_CLK1_BIT = 3;

    // Values after reset and on loss of signal
    localparam logic CTRL_LOOPBACK_RST = 1'b0;
    localparam logic CTRL_ALIGN_RST = 1'b0;
    localparam logic [WORD_W-1:0] WORD_RST = 10'h000;
    localparam logic [WORD_W-1:0] WORD_ALL_ONES = 10'h3FF;

    // Comma prefix, earliest bit in bit 0: 0,0,1,1,1,1,1
    localparam logic [6:0] COMMA_PREFIX = 7'h7C;

    // Timing: the serial bit period is far below one system clock, so it floors to one cycle
    localparam int SYS_CLK_PS = 25000;
    localparam int BIT_TIME_PS = 800;
    localparam int BIT_CYCLES = (BIT_TIME_PS / SYS_CLK_PS) < 1 ? 1 : BIT_TIME_PS / SYS_CLK_PS;
    localparam int BIT_CNT_W = 8;
    localparam int LAST_BIT = WORD_W - 1;

    typedef enum logic [0:0] {
        SER_IDLE = 1'b0,
        SER_SHIFT = 1'b1
    } ser_state_e;

endpackage

// ### src/word_buffer.sv
// Small valid/ready buffer for transmit words
`timescale 1ns/1ps
module word_buffer #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
        $error("word_buffer DEPTH must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PTR_W-1:0] wr_ptr_r;
    logic [PTR_W-1:0] rd_ptr_r;
    logic [CNT_W-1:0] count_r;
    logic push;
    logic pop;

    assign in_ready = (count_r != CNT_W'(DEPTH));
    assign out_valid = (count_r != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            count_r <= count_r + CNT_W'(push) - CNT_W'(pop);
        end
    end

    // Registered head so the read data come straight from a flop
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            out_data <= '0;
        end else if (pop && count_r > CNT_W'(1)) begin
            out_data <= mem_r[rd_ptr_r + 1'b1];
        end else if (push && (count_r == '0 || (pop && count_r == CNT_W'(1)))) begin
            out_data <= in_data;
        end
    end

endmodule

// ### src/serdes_word_path.sv
// Serdes word path: transmit capture and serializer, receive deserializer, comma alignment, APB registers
`timescale 1ns/1ps
module serdes_word_path #(
    parameter int BUF_DEPTH = 2
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // APB slave
    input wire logic [serdes_word_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [serdes_word_pkg::DATA_W-1:0] pwdata,
    output logic [serdes_word_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Host transmit side
    input wire logic tx_ref_clk,
    input wire logic [serdes_word_pkg::WORD_W-1:0] tx_word,
    output logic tx_word_ready,
    // Serial line
    input wire logic line_rx_in,
    input wire logic line_level_ok,
    output logic line_tx_p,
    output logic line_tx_n,
    // Host receive side
    output logic [serdes_word_pkg::WORD_W-1:0] rx_word,
    output logic rx_byte_clk0,
    output logic rx_byte_clk1,
    output logic comma_found,
    output logic line_signal_present
);
    localparam int W = serdes_word_pkg::WORD_W;
    localparam int CW = serdes_word_pkg::BIT_CNT_W;

    if (BUF_DEPTH < 2) begin : g_buf_check
        $error("serdes_word_path BUF_DEPTH must be at least 2");
    end

    function automatic logic is_comma(input logic [W-1:0] w);
        return w[6:0] == serdes_word_pkg::COMMA_PREFIX;
    endfunction

    // Pin synchronisers: only the second stage is read by logic
    logic [serdes_word_pkg::SYNC_W-1:0] sync1_r;
    logic [serdes_word_pkg::SYNC_W-1:0] sync2_r;
    logic ref_s;
    logic [W-1:0] tx_word_s;
    logic rx_in_s;
    logic level_s;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= {line_level_ok, line_rx_in, tx_word, tx_ref_clk};
            sync2_r <= sync1_r;
        end
    end

    assign ref_s = sync2_r[0];
    assign tx_word_s = sync2_r[W:1];
    assign rx_in_s = sync2_r[W+1];
    assign level_s = sync2_r[W+2];

    // Control and status registers
    logic loopback_r;
    logic align_r;
    logic [serdes_word_pkg::DATA_W-1:0] prdata_r;

    // Reference clock edge and holding register
    logic ref_d_r;
    logic ref_rise;
    logic [W-1:0] hold_r;
    logic hold_valid_r;
    logic buf_in_ready;
    logic buf_out_valid;
    logic buf_out_ready;
    logic [W-1:0] buf_out_data;

    assign ref_rise = ref_s && !ref_d_r;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ref_d_r <= 1'b0;
        end else begin
            ref_d_r <= ref_s;
        end
    end

    // Words are taken as given: line coding belongs to the host
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            hold_r <= serdes_word_pkg::WORD_RST;
            hold_valid_r <= 1'b0;
        end else begin
            if (ref_rise) begin
                hold_r <= tx_word_s;
            end
            // Holding slot frees once the buffer takes it; a new edge refills it
            if (ref_rise) begin
                hold_valid_r <= 1'b1;
            end else if (buf_in_ready) begin
                hold_valid_r <= 1'b0;
            end
        end
    end

    // Host sees back-pressure: a full buffer means the next edge overwrites the slot
    assign tx_word_ready = buf_in_ready || !hold_valid_r;

    word_buffer #(
        .WIDTH(W),
        .DEPTH(BUF_DEPTH)
    ) u_tx_buffer (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .in_valid(hold_valid_r),
        .in_ready(buf_in_ready),
        .in_data(hold_r),
        .out_valid(buf_out_valid),
        .out_ready(buf_out_ready),
        .out_data(buf_out_data)
    );

    // Bit period strobe shared by serializer and receiver
    logic [CW-1:0] bit_tmr_r;
    logic bit_stb;

    assign bit_stb = (bit_tmr_r == CW'(serdes_word_pkg::BIT_CYCLES - 1));

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            bit_tmr_r <= '0;
        end else if (bit_stb) begin
            bit_tmr_r <= '0;
        end else begin
            bit_tmr_r <= bit_tmr_r + 1'b1;
        end
    end

    // Serializer
    serdes_word_pkg::ser_state_e ser_state_r;
    logic [W-1:0] ser_sr_r;
    logic [CW-1:0] ser_cnt_r;
    logic ser_bit;
    logic ser_load;

    assign ser_load = bit_stb && buf_out_valid
        && (ser_state_r == serdes_word_pkg::SER_IDLE
            || ser_cnt_r == CW'(serdes_word_pkg::LAST_BIT));
    assign buf_out_ready = ser_load;
    // An empty buffer idles the line at zero between words
    assign ser_bit = (ser_state_r == serdes_word_pkg::SER_SHIFT) ? ser_sr_r[0] : 1'b0;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ser_state_r <= serdes_word_pkg::SER_IDLE;
            ser_sr_r <= serdes_word_pkg::WORD_RST;
            ser_cnt_r <= '0;
        end else if (bit_stb) begin
            unique case (ser_state_r)
                serdes_word_pkg::SER_IDLE: begin
                    if (buf_out_valid) begin
                        ser_state_r <= serdes_word_pkg::SER_SHIFT;
                        ser_sr_r <= buf_out_data;
                        ser_cnt_r <= '0;
                    end
                end
                serdes_word_pkg::SER_SHIFT: begin
                    if (ser_cnt_r == CW'(serdes_word_pkg::LAST_BIT)) begin
                        if (buf_out_valid) begin
                            ser_sr_r <= buf_out_data;
                            ser_cnt_r <= '0;
                        end else begin
                            ser_state_r <= serdes_word_pkg::SER_IDLE;
                        end
                    end else begin
                        ser_sr_r <= {1'b0, ser_sr_r[W-1:1]};
                        ser_cnt_r <= ser_cnt_r + 1'b1;
                    end
                end
            endcase
        end
    end

    // Line driver, registered so the pins never glitch
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            line_tx_p <= 1'b1;
            line_tx_n <= 1'b0;
        end else if (loopback_r) begin
            line_tx_p <= 1'b1;
            line_tx_n <= 1'b0;
        end else begin
            line_tx_p <= ser_bit;
            line_tx_n <= !ser_bit;
        end
    end

    // Receive source select
    logic rx_bit;

    assign rx_bit = loopback_r ? ser_bit : rx_in_s;

    // Deserializer and comma alignment
    logic [W-1:0] des_sr_r;
    logic [W-1:0] des_nxt;
    logic [CW-1:0] des_cnt_r;
    logic comma_hit;
    logic word_done;
    logic phase_r;

    assign des_nxt = {rx_bit, des_sr_r[W-1:1]};
    assign comma_hit = align_r && is_comma(des_nxt);
    assign word_done = (des_cnt_r == CW'(serdes_word_pkg::LAST_BIT)) || comma_hit;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            des_sr_r <= serdes_word_pkg::WORD_RST;
            des_cnt_r <= '0;
        end else if (bit_stb) begin
            des_sr_r <= des_nxt;
            des_cnt_r <= word_done ? '0 : des_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            line_signal_present <= 1'b0;
        end else begin
            line_signal_present <= level_s;
        end
    end

    // Word output; lost signal overrides data at once
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rx_word <= serdes_word_pkg::WORD_RST;
        end else if (!level_s) begin
            rx_word <= serdes_word_pkg::WORD_ALL_ONES;
        end else if (bit_stb && word_done) begin
            rx_word <= des_nxt;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            comma_found <= 1'b0;
        end else if (!align_r || !level_s) begin
            comma_found <= 1'b0;
        end else if (bit_stb && word_done) begin
            comma_found <= comma_hit;
        end
    end

    // Byte clocks: opposite phases, each rising once every two words, a comma toggles them like any other word
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            phase_r <= 1'b0;
        end else if (bit_stb && word_done && level_s) begin
            // A comma during a high phase drops low first so the next word edge still rises
            phase_r <= (comma_hit && !phase_r) ? 1'b1 : !phase_r;
        end
    end

    assign rx_byte_clk1 = phase_r;
    assign rx_byte_clk0 = !phase_r;

    // APB slave: zero wait states, read data captured in the setup cycle
    logic setup_ph;
    logic access_ph;
    logic mapped;

    assign setup_ph = psel && !penable;
    assign access_ph = psel && penable;
    assign mapped = (paddr == serdes_word_pkg::REG_CTRL) || (paddr == serdes_word_pkg::REG_STATUS)
        || (paddr == serdes_word_pkg::REG_RX_WORD) || (paddr == serdes_word_pkg::REG_TX_HOLD);
    assign pready = 1'b1;
    assign pslverr = access_ph && !mapped;
    assign prdata = prdata_r;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            loopback_r <= serdes_word_pkg::CTRL_LOOPBACK_RST;
            align_r <= serdes_word_pkg::CTRL_ALIGN_RST;
        end else if (access_ph && pwrite && paddr == serdes_word_pkg::REG_CTRL) begin
            loopback_r <= pwdata[serdes_word_pkg::CTRL_LOOPBACK_BIT];
            align_r <= pwdata[serdes_word_pkg::CTRL_ALIGN_BIT];
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            prdata_r <= '0;
        end else if (setup_ph && !pwrite) begin
            prdata_r <= '0;
            unique case (paddr)
                serdes_word_pkg::REG_CTRL: begin
                    prdata_r[serdes_word_pkg::CTRL_LOOPBACK_BIT] <= loopback_r;
                    prdata_r[serdes_word_pkg::CTRL_ALIGN_BIT] <= align_r;
                end
                serdes_word_pkg::REG_STATUS: begin
                    prdata_r[serdes_word_pkg::ST_SIGNAL_BIT] <= line_signal_present;
                    prdata_r[serdes_word_pkg::ST_COMMA_BIT] <= comma_found;
                    prdata_r[serdes_word_pkg::ST_TX_READY_BIT] <= tx_word_ready;
                    prdata_r[serdes_word_pkg::ST_BYTE_CLK1_BIT] <= phase_r;
                end
                serdes_word_pkg::REG_RX_WORD: begin
                    prdata_r[W-1:0] <= rx_word;
                end
                serdes_word_pkg::REG_TX_HOLD: begin
                    prdata_r[W-1:0] <= hold_r;
                end
                default: begin
                    prdata_r <= '0;
                end
            endcase
        end
    end

endmodule

// ### tb/serdes_word_monitor.sv
// Concurrent checks on the serdes word path pins
`timescale 1ns/1ps
module serdes_word_monitor (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // APB
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic pslverr,
    // Line and receive side
    input wire logic line_level_ok,
    input wire logic line_tx_p,
    input wire logic line_tx_n,
    input wire logic [9:0] rx_word,
    input wire logic rx_byte_clk0,
    input wire logic rx_byte_clk1,
    input wire logic comma_found,
    input wire logic line_signal_present
);
    // Control bits are not pins, so they are shadowed from the bus writes
    logic lb_r;
    logic al_r;
    logic seen_r;
    logic wr_ctrl;
    assign wr_ctrl = psel && penable && pwrite && paddr == serdes_word_pkg::REG_CTRL;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            lb_r <= 1'b0;
            al_r <= 1'b0;
        end else if (wr_ctrl) begin
            lb_r <= pwdata[0];
            al_r <= pwdata[1];
        end
    end
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            seen_r <= 1'b0;
        end else if (line_signal_present) begin
            seen_r <= 1'b1;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    a_loop_static: assert property (lb_r && $past(lb_r) |-> line_tx_p && !line_tx_n)
        else $error("line not static one in loopback");
    a_legs_opposed: assert property (line_tx_n == !line_tx_p)
        else $error("line legs not complementary");
    a_comma_gated: assert property (!al_r && $past(!al_r) |-> !comma_found)
        else $error("comma flag with alignment off");
    a_comma_shape: assert property ($rose(comma_found) |-> rx_word[6:0] == serdes_word_pkg::COMMA_PREFIX)
        else $error("comma flag without comma word");
    a_loss_flag: assert property ($fell(line_level_ok) |-> ##[1:4] !line_signal_present)
        else $error("signal present stays high on loss");
    a_level_back: assert property ($rose(line_level_ok) |-> ##[1:4] line_signal_present)
        else $error("signal present stays low");
    a_loss_ones: assert property (seen_r && !line_signal_present && $past(!line_signal_present) |-> rx_word == 10'h3FF)
        else $error("word not all ones on loss");
    a_clk_opposed: assert property (rx_byte_clk0 == !rx_byte_clk1)
        else $error("byte clocks not opposed");
    a_unmapped_err: assert property (psel && penable && paddr > serdes_word_pkg::REG_TX_HOLD |-> pslverr)
        else $error("no error on unmapped access");
    c_loop_comma: cover property (lb_r && $rose(comma_found));
    c_ext_comma: cover property (!lb_r && $rose(comma_found));
    c_loss: cover property ($fell(line_signal_present));
endmodule
bind serdes_word_path serdes_word_monitor serdes_word_monitor_i (.sys_clk(sys_clk), .rstn(rstn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pslverr(pslverr),
    .line_level_ok(line_level_ok), .line_tx_p(line_tx_p), .line_tx_n(line_tx_n), .rx_word(rx_word),
    .rx_byte_clk0(rx_byte_clk0), .rx_byte_clk1(rx_byte_clk1), .comma_found(comma_found),
    .line_signal_present(line_signal_present));

// ### tb/line_far_end.sv
// Far end of the serial line: sends coded words one bit per cycle
`timescale 1ns/1ps
module line_far_end (
    // Control
    input wire logic sys_clk,
    input wire logic level_en,
    input wire logic [9:0] word,
    output logic take,
    // Line
    output logic line_rx_in,
    output logic line_level_ok
);
    logic [9:0] sh;
    int cnt;
    initial begin
        sh = 10'h000;
        cnt = 0;
        take = 1'b0;
        line_rx_in = 1'b0;
        line_level_ok = 1'b0;
    end
    always @(posedge sys_clk) begin
        line_level_ok <= level_en;
        if (!level_en) begin
            // A dead line must not look like a held bit
            line_rx_in <= ~line_rx_in;
            take <= 1'b0;
            cnt <= 0;
        end else begin
            // Words go out as handed over, already coded
            line_rx_in <= (cnt == 0) ? word[0] : sh[0];
            sh <= (cnt == 0) ? word >> 1 : sh >> 1;
            take <= (cnt == 0);
            cnt <= (cnt == 9) ? 0 : cnt + 1;
        end
    end
endmodule

// ### tb/testbench.sv
// Self-checking bench for the serdes word path
`timescale 1ns/1ps
module testbench;
    logic sys_clk, rstn, psel, penable, pwrite, tx_ref_clk, level_en, take, pready, pslverr, tx_word_ready;
    logic line_rx_in, line_level_ok, line_tx_p, line_tx_n, rx_byte_clk0, rx_byte_clk1, comma_found;
    logic line_signal_present, err, rx_sync, lb, saw_full, saw_cf, cf_prev, clk1_prev, p1;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, lfsr;
    logic [9:0] tx_word, rx_word, far_word, far_fill, w;
    logic [9:0] tx_exp[$], rx_exp[$], far_q[$];
    int mismatches, n_checks, i, n, t0;
    localparam logic [9:0] COMMA_W = 10'h17C;
    localparam logic [9:0] FILL_W = 10'h155;
    serdes_word_path serdes_word_path_i (.sys_clk(sys_clk), .rstn(rstn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tx_ref_clk(tx_ref_clk), .tx_word(tx_word), .tx_word_ready(tx_word_ready),
        .line_rx_in(line_rx_in), .line_level_ok(line_level_ok), .line_tx_p(line_tx_p), .line_tx_n(line_tx_n),
        .rx_word(rx_word), .rx_byte_clk0(rx_byte_clk0), .rx_byte_clk1(rx_byte_clk1),
        .comma_found(comma_found), .line_signal_present(line_signal_present));
    line_far_end line_far_end_i (.sys_clk(sys_clk), .level_en(level_en), .word(far_word), .take(take),
        .line_rx_in(line_rx_in), .line_level_ok(line_level_ok));
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task give_up();
        mismatches++;
        report_and_stop();
    endtask
    function logic [9:0] rnd_word();
        lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04C11DB7 : 32'h00000000);
        // Zeros at bits 2, 5 and 8 keep any stream of these free of commas
        return (lfsr[9:0] & 10'h2DB) | 10'h001;
    endfunction
    task apb(input logic [11:0] a, input logic wr, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) give_up();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task send_word(input logic [9:0] v);
        int k;
        k = 0;
        @(negedge sys_clk);
        while (tx_word_ready !== 1'b1 && k < 200) begin
            saw_full = 1'b1;
            @(negedge sys_clk);
            k++;
        end
        if (k >= 200) give_up();
        @(posedge sys_clk);
        tx_word <= v;
        if (!lb) tx_exp.push_back(v);
        repeat (4) @(posedge sys_clk);
        tx_ref_clk <= 1'b1;
        // The next call spends one more cycle before its edge, so the reference period stays at 8 cycles
        repeat (3) @(posedge sys_clk);
        tx_ref_clk <= 1'b0;
    endtask
    task wait_drain();
        int k;
        for (k = 0; k < 3000 && tx_exp.size() + rx_exp.size() + far_q.size() > 0; k++) @(posedge sys_clk);
        if (k >= 3000) give_up();
        repeat (30) @(posedge sys_clk);
    endtask
    always @(posedge sys_clk) begin
        if (take === 1'b1) far_word <= (far_q.size() > 0) ? far_q.pop_front() : far_fill;
    end
    initial begin
        logic [9:0] v;
        forever begin
            @(negedge sys_clk);
            if (tx_exp.size() > 0) begin
                v = tx_exp.pop_front();
                for (n = 0; n < 200 && line_tx_p !== 1'b1; n++) @(negedge sys_clk);
                if (n >= 200) give_up();
                for (int b = 0; b < 10; b++) begin
                    if (b > 0) @(negedge sys_clk);
                    check("line_tx_p", line_tx_p, v[b]);
                end
            end
        end
    end
    always @(negedge sys_clk) begin
        if (comma_found === 1'b1 && cf_prev === 1'b0) begin
            check("comma word", rx_word, COMMA_W);
            rx_sync = 1'b1;
        end else if (rx_sync && rx_byte_clk1 !== clk1_prev && rx_exp.size() > 0) begin
            check("rx_word", rx_word, rx_exp.pop_front());
        end
        cf_prev = comma_found;
        clk1_prev = rx_byte_clk1;
    end
    initial begin
        {rstn, psel, penable, pwrite, tx_ref_clk, level_en, rx_sync, lb, saw_full, cf_prev, clk1_prev} = 11'h000;
        {paddr, pwdata, tx_word, mismatches, n_checks} = '0;
        far_word = FILL_W;
        far_fill = FILL_W;
        lfsr = 32'h89C61F2C;
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        apb(serdes_word_pkg::REG_CTRL, 1'b0, 32'h0);
        check("ctrl reset", rd, 32'h0);
        apb(12'h010, 1'b1, 32'h3);
        check("unmapped write err", err, 1'b1);
        apb(12'h010, 1'b0, 32'h0);
        check("unmapped read err", err, 1'b1);
        check("unmapped read data", rd, 32'h0);
        apb(serdes_word_pkg::REG_CTRL, 1'b1, (lfsr & 32'hFFFFFFFC) | 32'h2);
        apb(serdes_word_pkg::REG_CTRL, 1'b0, 32'h0);
        check("ctrl readback", rd, 32'h2);
        level_en <= 1'b1;
        repeat (20) send_word(rnd_word());
        check("tx buffer filled", saw_full, 1'b1);
        wait_drain();
        // Far end sends commas in loopback, so a wrong source is visible
        far_fill = COMMA_W;
        lb = 1'b1;
        rx_sync = 1'b0;
        apb(serdes_word_pkg::REG_CTRL, 1'b1, 32'h3);
        repeat (3) @(posedge sys_clk);
        check("loop p", line_tx_p, 1'b1);
        check("loop n", line_tx_n, 1'b0);
        send_word(COMMA_W);
        repeat (6) begin
            w = rnd_word();
            rx_exp.push_back(w);
            send_word(w);
        end
        wait_drain();
        lb = 1'b0;
        far_fill = FILL_W;
        apb(serdes_word_pkg::REG_CTRL, 1'b1, 32'h2);
        repeat (30) @(posedge sys_clk);
        // Late commas still on the line from the loopback phase must not become the sync point
        rx_sync = 1'b0;
        far_q.push_back(COMMA_W);
        repeat (6) begin
            w = rnd_word();
            far_q.push_back(w);
            rx_exp.push_back(w);
        end
        wait_drain();
        p1 = rx_byte_clk1;
        n = 0;
        t0 = 0;
        for (i = 0; i < 100 && n < 2; i++) begin
            @(negedge sys_clk);
            if (rx_byte_clk1 === 1'b1 && p1 === 1'b0) begin
                n++;
                if (n == 1) t0 = i;
            end
            p1 = rx_byte_clk1;
        end
        check("byte clock period", i - 1 - t0, 2 * serdes_word_pkg::WORD_W);
        @(posedge sys_clk);
        apb(serdes_word_pkg::REG_CTRL, 1'b1, 32'h0);
        far_fill = COMMA_W;
        saw_cf = 1'b0;
        repeat (60) begin
            @(negedge sys_clk);
            if (comma_found !== 1'b0) saw_cf = 1'b1;
        end
        check("comma while off", saw_cf, 1'b0);
        @(posedge sys_clk);
        level_en <= 1'b0;
        repeat (6) @(posedge sys_clk);
        apb(serdes_word_pkg::REG_STATUS, 1'b0, 32'h0);
        check("status present", rd[0], 1'b0);
        check("lost present", line_signal_present, 1'b0);
        check("lost word", rx_word, 10'h3FF);
        report_and_stop();
    end
endmodule
